// ==== src/mpot_setpoint.sv ====
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module mpot_setpoint
(
  input  wire logic        pclk,            // Processing clock, 125 MHz.
  input  wire logic        presetn,         // Asynchronous reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB access phase.
  input  wire logic        pwrite,          // APB write when high.
  input  wire logic [7:0]  paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic      [31:0] prdata,          // APB read data.
  output logic             pready,          // APB ready.
  output logic             pslverr,         // APB error, unmapped address.
  input  wire mpot_pkg::mpot_req_s req_in,  // Raise, lower, preload from outside.
  output logic signed [15:0] pot_output     // Setpoint in hundredths of a percent.
);
  import mpot_pkg::*;

  // =================================================================
  // Helpers
  // =================================================================
  // Saturate a level into a window.
  function automatic logic signed [15:0] clamp_level(input logic signed [15:0] v,
                                                     input logic signed [15:0] lo,
                                                     input logic signed [15:0] hi);
    logic signed [15:0] r;
    r = v;
    if (r > hi)
      r = hi;
    if (r < lo)
      r = lo;
    return r;
  endfunction

  // Saturate a written rate into its legal range.
  function automatic logic [12:0] clamp_rate(input logic [31:0] v);
    logic [12:0] r;
    r = v[12:0];
    if (v > {19'h00000, RATE_MAX})
      r = RATE_MAX;
    else if (v[12:0] < RATE_MIN)
      r = RATE_MIN;
    return r;
  endfunction

  // =================================================================
  // Input synchronisers
  // =================================================================
  mpot_req_s req_meta_q;
  mpot_req_s req_q;

  // Requests arrive from pins or other logic; two stages before use.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_meta_q <= '0;
      req_q      <= '0;
    end
    else
    begin
      req_meta_q <= req_in;
      req_q      <= req_meta_q;
    end
  end

  // =================================================================
  // Register file
  // =================================================================
  mpot_cfg_s   cfg_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        bus_done;
  logic        addr_ok;
  logic [31:0] rd_word;
  logic [3:0]  status_w;
  logic signed [15:0] out_q;

  assign bus_done = psel && penable && pready_q;
  assign addr_ok  = (paddr == OFS_PRELOAD) || (paddr == OFS_AWAY_TIME) ||
                    (paddr == OFS_TOWARD) || (paddr == OFS_LOWER_LIM) ||
                    (paddr == OFS_UPPER_LIM) || (paddr == OFS_OUTPUT) ||
                    (paddr == OFS_STATUS);

  // Read mux; narrow values are sign or zero extended, unused bits read zero.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFS_PRELOAD:   rd_word = {{16{cfg_q.preload_level[15]}}, cfg_q.preload_level};
      OFS_AWAY_TIME: rd_word = {19'h00000, cfg_q.away_from_zero_time};
      OFS_TOWARD:    rd_word = {19'h00000, cfg_q.toward_zero_time};
      OFS_LOWER_LIM: rd_word = {{16{cfg_q.lower_limit[15]}}, cfg_q.lower_limit};
      OFS_UPPER_LIM: rd_word = {{16{cfg_q.upper_limit[15]}}, cfg_q.upper_limit};
      OFS_OUTPUT:    rd_word = {{16{out_q[15]}}, out_q};
      OFS_STATUS:    rd_word = {28'h0000000, status_w};
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // One wait state: ready and data are registered so every output is a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_ok;
      prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Writes land only at the completing edge; writes to output and status are ignored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q.preload_level       <= RST_PRELOAD;
      cfg_q.away_from_zero_time <= RST_RATE;
      cfg_q.toward_zero_time    <= RST_RATE;
      cfg_q.lower_limit         <= RST_LOWER_LIM;
      cfg_q.upper_limit         <= RST_UPPER_LIM;
    end
    else if (bus_done && pwrite)
    begin
      unique case (paddr)
        OFS_PRELOAD:   cfg_q.preload_level <= clamp_level(pwdata[15:0], LEVEL_MIN, LEVEL_MAX);
        OFS_AWAY_TIME: cfg_q.away_from_zero_time <= clamp_rate(pwdata);
        OFS_TOWARD:    cfg_q.toward_zero_time <= clamp_rate(pwdata);
        OFS_LOWER_LIM: cfg_q.lower_limit <= clamp_level(pwdata[15:0], LEVEL_MIN, LEVEL_MAX);
        OFS_UPPER_LIM: cfg_q.upper_limit <= clamp_level(pwdata[15:0], LEVEL_MIN, LEVEL_MAX);
        default:       cfg_q <= cfg_q;
      endcase
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // =================================================================
  // Ramp engine
  // =================================================================
  logic               pwr_q;
  logic [CNT_W-1:0]   cnt_q;
  logic               inverted;
  logic               up_sel;
  logic               dn_sel;
  logic               moving;
  logic               away;
  logic [12:0]        rate_sel;
  logic [CNT_W-1:0]   limit;
  logic               step_now;
  logic signed [15:0] preload_cl;
  logic signed [15:0] base;
  logic signed [15:0] out_d;

  assign inverted   = cfg_q.lower_limit > cfg_q.upper_limit;
  assign up_sel     = req_q.raise_request && !req_q.lower_request;
  assign dn_sel     = req_q.lower_request && !req_q.raise_request;
  assign moving     = (up_sel || dn_sel) && !req_q.preload_request && !pwr_q;
  // Growing magnitude means away from zero; zero itself counts as away.
  assign away       = up_sel ? (out_q >= 16'sh0000) : (out_q <= 16'sh0000);
  assign rate_sel   = away ? cfg_q.away_from_zero_time : cfg_q.toward_zero_time;
  // One hundredth per rate*10 us gives a 100 % change in the set time.
  assign limit      = CNT_W'(rate_sel * STEP_UNIT_CYC);
  assign step_now   = moving && (cnt_q >= limit - 24'h000001);
  assign preload_cl = clamp_level(cfg_q.preload_level, cfg_q.lower_limit,
                                  cfg_q.upper_limit);

  // Cycle counter paces the steps; it restarts whenever the ramp is idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!moving || step_now)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 24'h000001;
  end

  // Power-up marker; the output is not retained, so it starts from preload.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_q <= 1'b1;
    else
      pwr_q <= 1'b0;
  end

  // Next output: preload first, then single steps, then hard saturation.
  always_comb
  begin
    base = out_q;
    if (pwr_q || req_q.preload_request)
      base = preload_cl;
    else if (step_now && up_sel && out_q < cfg_q.upper_limit)
      base = out_q + 16'sh0001;
    else if (step_now && dn_sel && out_q > cfg_q.lower_limit)
      base = out_q - 16'sh0001;
    // Limits act as plain saturation, so a moved limit snaps the output at once.
    out_d = inverted ? 16'sh0000 : clamp_level(base, cfg_q.lower_limit,
                                               cfg_q.upper_limit);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= RST_PRELOAD;
    else
      out_q <= out_d;
  end

  assign pot_output = out_q;

  assign status_w[ST_AT_UPPER] = out_q == cfg_q.upper_limit;
  assign status_w[ST_AT_LOWER] = out_q == cfg_q.lower_limit;
  assign status_w[ST_FORCED]   = inverted;
  assign status_w[ST_MOVING]   = moving;

  // =================================================================
  // Assertions
  // =================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_preload_loads: assert property (req_q.preload_request && !inverted |=>
    pot_output == $past(preload_cl)) else $error("preload not loaded");
  a_preload_clamped: assert property (pwr_q && !inverted |=>
    pot_output == $past(preload_cl)) else $error("power-up load wrong");
  a_raise_step: assert property (step_now && up_sel && out_q < cfg_q.upper_limit
    && !inverted |=> pot_output == $past(out_q) + 16'sh0001) else $error("raise step missing");
  a_lower_step: assert property (step_now && dn_sel && out_q > cfg_q.lower_limit
    && !inverted |=> pot_output == $past(out_q) - 16'sh0001) else $error("lower step missing");
  a_step_pace: assert property (step_now |-> cnt_q == CNT_W'(rate_sel * STEP_UNIT_CYC)
    - 24'h000001) else $error("step pace wrong");
  a_away_rate: assert property (moving && up_sel && out_q > 16'sh0000 |->
    rate_sel == cfg_q.away_from_zero_time) else $error("away rate not used");
  a_toward_rate: assert property (moving && dn_sel && out_q > 16'sh0000 |->
    rate_sel == cfg_q.toward_zero_time) else $error("toward rate not used");
  a_rate_range: assert property (cfg_q.away_from_zero_time >= RATE_MIN &&
    cfg_q.toward_zero_time <= RATE_MAX) else $error("rate out of range");
  a_upper_bound: assert property (!inverted |=> pot_output <= $past(cfg_q.upper_limit))
    else $error("above upper limit");
  a_lower_bound: assert property (!inverted |=> pot_output >= $past(cfg_q.lower_limit))
    else $error("below lower limit");
  a_forced_zero: assert property (inverted |=> pot_output == 16'sh0000)
    else $error("not forced to zero");
  // A limit write moves the output one edge later, so settings must be steady in the antecedent.
  a_idle_hold: assert property (!moving && !pwr_q && !req_q.preload_request && !inverted
    && $stable(cfg_q) |=> $stable(pot_output))
    else $error("idle output moved");
  a_both_hold: assert property (req_q.raise_request && req_q.lower_request
    && !req_q.preload_request && !pwr_q && !inverted && $stable(cfg_q) |=> $stable(pot_output))
    else $error("both requests moved output");
  a_step_spacing: assert property (step_now |=> (!step_now) [*8])
    else $error("steps too close");
  a_ready_pulse: assert property (pready_q |=> !pready_q) else $error("ready held");

  c_raise: cover property (step_now && up_sel);
  c_lower: cover property (step_now && dn_sel);
  c_preload: cover property (req_q.preload_request ##1 !req_q.preload_request);
  c_forced: cover property (inverted);

endmodule // mpot_setpoint

// ==== src/mpot_pkg.sv ====
// =====================================================================
// Shared constants and carriers for the motorised pot setpoint block.
// =====================================================================
package mpot_pkg;

  // =================================================================
  // Value formats
  // =================================================================
  // Levels are signed hundredths of a percent, rates are tenths of a second.
  localparam int              LEVEL_W      = 16;
  localparam int              RATE_W       = 13;
  localparam int              CNT_W        = 24;
  localparam logic signed [15:0] LEVEL_MAX = 16'sh7530;  // +300.00 %.
  localparam logic signed [15:0] LEVEL_MIN = -16'sh7530; // -300.00 %.
  localparam logic [12:0]     RATE_MIN     = 13'h0001;   // 0.1 s.
  localparam logic [12:0]     RATE_MAX     = 13'h1770;   // 600.0 s.

  // =================================================================
  // Timing
  // =================================================================
  // One tenth of a second for a full 100 % change is 10000 hundredths,
  // so each hundredth takes 10 us per rate unit.
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int STEP_UNIT_PS   = 10000000;
  localparam int STEP_UNIT_CYC  = STEP_UNIT_PS / CLK_PERIOD_PS;

  // =================================================================
  // Register offsets (byte addresses) and reset values
  // =================================================================
  localparam logic [7:0] OFS_PRELOAD    = 8'h00;
  localparam logic [7:0] OFS_AWAY_TIME  = 8'h04;
  localparam logic [7:0] OFS_TOWARD     = 8'h08;
  localparam logic [7:0] OFS_LOWER_LIM  = 8'h0c;
  localparam logic [7:0] OFS_UPPER_LIM  = 8'h10;
  localparam logic [7:0] OFS_OUTPUT     = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;

  localparam logic signed [15:0] RST_PRELOAD   = 16'sh0000;  // 0.00 %.
  localparam logic [12:0]        RST_RATE      = 13'h0064;   // 10.0 s.
  localparam logic signed [15:0] RST_LOWER_LIM = -16'sh2710; // -100.00 %.
  localparam logic signed [15:0] RST_UPPER_LIM = 16'sh2710;  // +100.00 %.

  // Status register bit positions.
  localparam int ST_AT_UPPER = 0;
  localparam int ST_AT_LOWER = 1;
  localparam int ST_FORCED   = 2;
  localparam int ST_MOVING   = 3;

  // =================================================================
  // Carriers
  // =================================================================
  typedef struct packed {
    logic signed [15:0] preload_level;
    logic [12:0]        away_from_zero_time;
    logic [12:0]        toward_zero_time;
    logic signed [15:0] lower_limit;
    logic signed [15:0] upper_limit;
  } mpot_cfg_s;

  typedef struct packed {
    logic preload_request;
    logic raise_request;
    logic lower_request;
  } mpot_req_s;

endpackage

// ==== verification/mpot_req_src.sv ====
`timescale 1ns/1ps
// =====================================================================
// Far-side request source: the digital inputs that command the pot.
// =====================================================================
module mpot_req_src
(
  input  wire logic          pclk, // Processing clock.
  output mpot_pkg::mpot_req_s req   // Request levels toward the pot block.
);
  import mpot_pkg::*;

  // Levels start low so the block sees no command coming out of reset.
  initial req = '0;

  // Hold one request pattern for a number of cycles, then drop it.
  // Changes land just after an edge, so the synchroniser never sees a glitch.
  task automatic hold(input logic pre, input logic up, input logic dn, input int cycles);
    @(posedge pclk);
    req <= '{preload_request: pre, raise_request: up, lower_request: dn};
    repeat (cycles) @(posedge pclk);
    req <= '0;
  endtask
endmodule // mpot_req_src

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the motorised pot setpoint block.
// =====================================================================
module testbench;
  import mpot_pkg::*;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic               pready;
  logic               pslverr;
  logic               err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  mpot_req_s          req;
  logic signed [15:0] pot_output;
  int                 failures;
  int                 comparisons;
  int                 lo;
  int                 hi;
  int                 pl;

  mpot_setpoint DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_in(req), .pot_output(pot_output));
  mpot_req_src src (.pclk(pclk), .req(req));

  // =================================================================
  // Clock and run guard
  // =================================================================
  // 125 MHz processing clock.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // A hang anywhere ends the run as a failure.
  initial
  begin
    repeat (90000) @(posedge pclk);
    failures++;
    report_and_stop();
  end

  // =================================================================
  // Helpers
  // =================================================================
  task automatic report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Levels travel sign-extended in a 32-bit word.
  function automatic logic [31:0] sx(input int v);
    return 32'(v);
  endfunction

  // Preload after clamping; crossed limits force zero.
  function automatic logic [15:0] exp_clamp(input int p, input int l, input int h);
    if (l > h)
      return 16'h0000;
    if (p > h)
      return 16'(h);
    if (p < l)
      return 16'(l);
    return 16'(p);
  endfunction

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Apply a preload pulse and let the synchroniser and load settle.
  task automatic preload_pulse;
    src.hold(1'b1, 1'b0, 1'b0, 4);
    repeat (6) @(posedge pclk);
  endtask

  // =================================================================
  // Main sequence
  // =================================================================
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    failures = 0;
    comparisons = 0;
    void'($urandom(32'h03a4));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk16(pot_output, 16'h0000);
    apb(1'b0, OFS_PRELOAD, 32'h0); chk32(rd, 32'h0);
    apb(1'b0, OFS_LOWER_LIM, 32'h0); chk32(rd, sx(-10000));
    apb(1'b0, OFS_UPPER_LIM, 32'h0); chk32(rd, sx(10000));
    apb(1'b0, 8'h40, 32'h0); chk32({31'h0, err}, 32'h1);
    apb(1'b1, OFS_OUTPUT, 32'h5); chk16(pot_output, 16'h0000);
    // Rate settings saturate to the accepted range.
    apb(1'b1, OFS_AWAY_TIME, 32'h0); apb(1'b0, OFS_AWAY_TIME, 32'h0); chk32(rd, 32'h1);
    apb(1'b1, OFS_TOWARD, 32'h1b58); apb(1'b0, OFS_TOWARD, 32'h0); chk32(rd, 32'h1770);
    apb(1'b1, OFS_AWAY_TIME, 32'h1);
    apb(1'b1, OFS_TOWARD, 32'h2);
    // Away steps every 1250 cycles, toward steps every 2500; holds sit mid-step.
    src.hold(1'b0, 1'b1, 1'b0, 4350); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'h0003);
    src.hold(1'b0, 1'b0, 1'b1, 5600); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'h0001);
    repeat (3000) @(posedge pclk);
    chk16(pot_output, 16'h0001);
    apb(1'b1, OFS_PRELOAD, sx(-5)); preload_pulse();
    chk16(pot_output, 16'hfffb);
    src.hold(1'b0, 1'b1, 1'b0, 5600); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'hfffd);
    src.hold(1'b0, 1'b0, 1'b1, 4350); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'hfffa);
    src.hold(1'b0, 1'b1, 1'b1, 3000); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'hfffa);
    src.hold(1'b1, 1'b1, 1'b0, 3000); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'hfffb);
    // Limits: clamped preload, raise at the top, immediate saturation, crossed limits.
    apb(1'b1, OFS_UPPER_LIM, sx(2)); apb(1'b1, OFS_PRELOAD, sx(100)); preload_pulse();
    chk16(pot_output, 16'h0002);
    src.hold(1'b0, 1'b1, 1'b0, 3100); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'h0002);
    apb(1'b1, OFS_UPPER_LIM, sx(100)); apb(1'b1, OFS_LOWER_LIM, sx(10)); repeat (3) @(posedge pclk);
    chk16(pot_output, 16'h000a);
    src.hold(1'b0, 1'b0, 1'b1, 5600); repeat (6) @(posedge pclk);
    chk16(pot_output, 16'h000a);
    apb(1'b1, OFS_LOWER_LIM, sx(200)); repeat (3) @(posedge pclk);
    chk16(pot_output, 16'h0000);
    // Random limits and preload levels, crossed limits included.
    for (int i = 0; i < 6; i++)
    begin
      lo = int'($urandom_range(60000)) - 30000;
      hi = int'($urandom_range(60000)) - 30000;
      pl = int'($urandom_range(60000)) - 30000;
      apb(1'b1, OFS_LOWER_LIM, sx(lo));
      apb(1'b1, OFS_UPPER_LIM, sx(hi));
      apb(1'b1, OFS_PRELOAD, sx(pl));
      preload_pulse();
      chk16(pot_output, exp_clamp(pl, lo, hi));
    end
    // A second reset restarts from the default preload.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk16(pot_output, 16'h0000);
    apb(1'b0, OFS_PRELOAD, 32'h0); chk32(rd, 32'h0);
    report_and_stop();
  end
endmodule // testbench
